// ===== rtl/swp_pkg.sv
package swp_pkg;

   // Bus addresses that the sweep board answers to.
   localparam logic [7:0] ADDR_SUB = 8'h0f;
   localparam logic [7:0] ADDR_CTRL = 8'h1f;
   localparam logic [7:0] ADDR_STATUS = 8'h9f;
   localparam int ADDR_MSB_POS = 7;

   // Control register at the second write address.
   localparam int CTRL_ABORT_POS = 0;
   localparam int CTRL_INHIBIT_POS = 1;
   localparam int CTRL_BLANK_POS = 2;
   localparam int CTRL_START_POS = 3;
   localparam int CTRL_SEL_LSB = 6;

   // Subregister 0 fields.
   localparam int SUB0_SINGLE_POS = 0;
   localparam int SUB0_EOS_EN_POS = 1;
   localparam int SUB0_SRC_LSB = 3;
   localparam int SUB0_HOLD_LSB = 5;

   // Subregister 1 holds the five-bit sweep rate code.
   localparam int RATE_W = 5;
   localparam logic [RATE_W-1:0] RATE_MANUAL = 5'h1f;
   localparam logic [RATE_W-1:0] RATE_EXTERNAL = 5'h0f;

   // Subregisters 2 and 3 hold the marker level, low byte first.
   localparam int MARKER_W = 12;

   // Reset values of the stored registers.
   localparam logic [7:0] SUB_RESET = 8'h00;
   localparam logic [1:0] SEL_RESET = 2'h0;

   // Status word at the read address.
   localparam int STAT_ACTIVE_POS = 0;
   localparam int STAT_HOLDOFF_POS = 1;
   localparam int STAT_PENDING_POS = 2;
   localparam int STAT_SRQ_LINE_POS = 3;

   // Poll handshake.
   localparam int POLL_RESPONSE_BIT = 4;
   localparam logic [7:0] ACK_WORD = 8'hef;

   // Trigger sources.
   typedef enum logic [1:0]
   {
      SWP_SRC_FREE = 2'h0,
      SWP_SRC_INTERNAL = 2'h1,
      SWP_SRC_EXTERNAL = 2'h2,
      SWP_SRC_LINE = 2'h3
   } swp_src_t;

   // Holdoff lengths; code 3 is unlisted and behaves as long.
   localparam logic [1:0] HOLD_SHORT = 2'h0;
   localparam logic [1:0] HOLD_MEDIUM = 2'h1;
   localparam logic [1:0] HOLD_LONG = 2'h2;

   // Holdoff times in nanoseconds and their cycle counts at 200 MHz.
   localparam int CLK_PERIOD_NS = 5;
   localparam int HOLD_SHORT_NS = 2000;
   localparam int HOLD_MEDIUM_NS = 10000;
   localparam int HOLD_LONG_NS = 20000;
   localparam int HOLD_CNT_W = 12;
   localparam logic [HOLD_CNT_W-1:0] HOLD_SHORT_CYC =
      HOLD_CNT_W'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [HOLD_CNT_W-1:0] HOLD_MEDIUM_CYC =
      HOLD_CNT_W'((HOLD_MEDIUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [HOLD_CNT_W-1:0] HOLD_LONG_CYC =
      HOLD_CNT_W'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Sweep state; reset lands in armed, so the first sweep needs no holdoff.
   typedef enum logic [1:0]
   {
      SWP_HOLD = 2'b00,
      SWP_ARMED = 2'b01,
      SWP_SWEEP = 2'b11
   } swp_state_t;

endpackage

// ===== rtl/swp_holdoff_timer.sv
`timescale 1ns/1ps
module swp_holdoff_timer
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Control.
   input wire logic start_i,
   input wire logic [1:0] length_i,
   // Status.
   output logic busy_o,
   output logic done_o
);
   import swp_pkg::*;


   logic [HOLD_CNT_W-1:0] count;
   logic [HOLD_CNT_W-1:0] next_count;
   logic next_busy;
   logic next_done;
   logic [HOLD_CNT_W-1:0] load;

   // Length decode; the unlisted code falls through to the long holdoff.
   always_comb
   begin
      unique case (length_i)
         HOLD_SHORT: load = HOLD_SHORT_CYC;
         HOLD_MEDIUM: load = HOLD_MEDIUM_CYC;
         HOLD_LONG: load = HOLD_LONG_CYC;
         default: load = HOLD_LONG_CYC;
      endcase
   end

   // A start reloads the count even while a holdoff is already running.
   always_comb
   begin
      next_count = count;
      next_busy = busy_o;
      next_done = 1'b0;
      if (start_i)
      begin
         next_count = load;
         next_busy = 1'b1;
      end
      else if (busy_o)
      begin
         next_count = count - HOLD_CNT_W'(1);
         if (count == HOLD_CNT_W'(1))
         begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   // Registers only.
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         count <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         count <= next_count;
         busy_o <= next_busy;
         done_o <= next_done;
      end
   end

endmodule

// ===== rtl/swp_sweep_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Decode 0F, 1F writes, 9F read only.
// - Control bits 6-7 pick the 0F subregister.
// - Control bit 3 starts a single sweep.
// - Subregister 1 holds five-bit sweep rate code.
// - Control bit 0 aborts the running sweep.
// - Control bit 1 ignores all trigger events.
// - Control bit 2 kills gate, forces blanking.
// - Subregister 0 bits 3-4 pick trigger source.
// - Subregister 0 bits 5-6 pick holdoff length.
// - End-of-sweep pends only with enable bit set.
// - Pending latch pulls service request line low.
// - Address MSB watched for poll and acknowledge.
// - Poll, MSB high, pending: pull data bit 4.
// - Completing poll edge clears pending, disarms acknowledge.
module swp_sweep_ctrl
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Instrument bus, sampled on clk_i.
   input wire logic [7:0] bus_addr_i,
   input wire logic [7:0] bus_data_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic poll_i,
   output logic [7:0] bus_data_o,
   output logic [7:0] bus_data_oe_o,
   // Shared open-drain service request.
   input wire logic service_request_line_i,
   output logic service_request_line_o,
   output logic service_request_line_oe_o,
   // Sweep events and triggers.
   input wire logic end_of_sweep_event_i,
   input wire logic trig_internal_i,
   input wire logic trig_external_i,
   input wire logic trig_line_i,
   // Sweep controls.
   output logic sweep_active_o,
   output logic sweep_gate_o,
   output logic blank_o,
   output logic [swp_pkg::RATE_W-1:0] sweep_rate_o,
   output logic manual_sweep_o,
   output logic external_sweep_o,
   output logic [swp_pkg::MARKER_W-1:0] marker_dac_o
);
   import swp_pkg::*;

   localparam int EDGE_N = 5;
   localparam int E_INT = 0;
   localparam int E_EXT = 1;
   localparam int E_LINE = 2;
   localparam int E_EOS = 3;
   localparam int E_POLL = 4;

   logic [EDGE_N-1:0] edge_in;
   logic [EDGE_N-1:0] edge_prev;
   logic [EDGE_N-1:0] edge_rise;
   logic poll_fall;

   logic [7:0] sub [4];
   logic inhibit;
   logic blank_cmd;
   logic [1:0] sub_sel;
   logic [7:0] next_sub [4];
   logic next_inhibit;
   logic next_blank_cmd;
   logic [1:0] next_sub_sel;
   logic abort_cmd;
   logic start_cmd;

   swp_state_t state;
   swp_state_t next_state;
   logic hold_start;
   logic hold_busy;
   logic hold_done;
   logic trig_ok;
   logic free_mode;
   swp_src_t src;

   logic pending;
   logic ack_armed;
   logic next_pending;
   logic next_ack_armed;
   logic ack_fire;

   logic [7:0] next_data;
   logic [7:0] next_data_oe;
   logic next_gate;
   logic next_blank;
   logic next_active;

   // Rising-edge detect on triggers, end of sweep and poll.
   assign edge_in = {poll_i, end_of_sweep_event_i, trig_line_i, trig_external_i,
                     trig_internal_i};
   genvar gi;
   generate
      for (gi = 0; gi < EDGE_N; gi++)
      begin : g_edge
         assign edge_rise[gi] = edge_in[gi] & ~edge_prev[gi];
         always_ff @(posedge clk_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
               edge_prev[gi] <= 1'b0;
            else
               edge_prev[gi] <= edge_in[gi];
         end
      end
   endgenerate
   assign poll_fall = edge_prev[E_POLL] & ~poll_i;

   // Abort and single-start are strobes taken from the write, never stored.
   assign abort_cmd = bus_wr_i && (bus_addr_i == ADDR_CTRL) && bus_data_i[CTRL_ABORT_POS];
   assign start_cmd = bus_wr_i && (bus_addr_i == ADDR_CTRL) &&
                      bus_data_i[CTRL_START_POS] && sub[0][SUB0_SINGLE_POS];

   // Command register writes; other addresses leave everything unchanged.
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         next_sub[i] = sub[i];
      next_inhibit = inhibit;
      next_blank_cmd = blank_cmd;
      next_sub_sel = sub_sel;
      if (bus_wr_i && (bus_addr_i == ADDR_SUB))
         next_sub[sub_sel] = bus_data_i;
      if (bus_wr_i && (bus_addr_i == ADDR_CTRL))
      begin
         next_inhibit = bus_data_i[CTRL_INHIBIT_POS];
         next_blank_cmd = bus_data_i[CTRL_BLANK_POS];
         next_sub_sel = bus_data_i[CTRL_SEL_LSB +: 2];
      end
   end

   // Registers only.
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (int i = 0; i < 4; i++)
            sub[i] <= SUB_RESET;
         inhibit <= 1'b0;
         blank_cmd <= 1'b0;
         sub_sel <= SEL_RESET;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
            sub[i] <= next_sub[i];
         inhibit <= next_inhibit;
         blank_cmd <= next_blank_cmd;
         sub_sel <= next_sub_sel;
      end
   end

   // Trigger qualification; free run needs no edge at all.
   assign src = swp_src_t'(sub[0][SUB0_SRC_LSB +: 2]);
   always_comb
   begin
      unique case (src)
         SWP_SRC_FREE: trig_ok = 1'b1;
         SWP_SRC_INTERNAL: trig_ok = edge_rise[E_INT];
         SWP_SRC_EXTERNAL: trig_ok = edge_rise[E_EXT];
         SWP_SRC_LINE: trig_ok = edge_rise[E_LINE];
      endcase
      if (inhibit)
         trig_ok = 1'b0;
   end
   assign free_mode = (sub[1][RATE_W-1:0] == RATE_MANUAL) ||
                      (sub[1][RATE_W-1:0] == RATE_EXTERNAL);

   // Holdoff timer; its length follows subregister 0 at the moment a sweep ends.
   swp_holdoff_timer u_holdoff
   (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .start_i(hold_start),
      .length_i(sub[0][SUB0_HOLD_LSB +: 2]),
      .busy_o(hold_busy),
      .done_o(hold_done)
   );

   // Sweep sequence: holdoff, armed, sweeping. Manual and external rate codes
   // start at once, because the ramp is then steered from outside.
   always_comb
   begin
      next_state = state;
      hold_start = 1'b0;
      unique case (state)
         SWP_HOLD:
         begin
            if (hold_done)
               next_state = SWP_ARMED;
         end
         SWP_ARMED:
         begin
            if (free_mode)
               next_state = SWP_SWEEP;
            else if (sub[0][SUB0_SINGLE_POS])
            begin
               if (start_cmd)
                  next_state = SWP_SWEEP;
            end
            else if (trig_ok)
               next_state = SWP_SWEEP;
         end
         SWP_SWEEP:
         begin
            if (abort_cmd || edge_rise[E_EOS])
            begin
               next_state = SWP_HOLD;
               hold_start = 1'b1;
            end
         end
      endcase
   end

   // Registers only; reset lands in armed because the timer is idle after reset.
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         state <= SWP_ARMED;
      else
         state <= next_state;
   end

   // Interrupt latches. A new end of sweep in the clearing cycle keeps the
   // request, so no event is lost to a late acknowledge.
   assign ack_fire = poll_fall && ack_armed;
   always_comb
   begin
      next_pending = pending;
      next_ack_armed = ack_armed;
      if (poll_i && !bus_addr_i[ADDR_MSB_POS] && (bus_data_i == ACK_WORD) && pending)
         next_ack_armed = 1'b1;
      if (poll_fall)
         next_ack_armed = 1'b0;
      if (ack_fire)
         next_pending = 1'b0;
      if (edge_rise[E_EOS] && sub[0][SUB0_EOS_EN_POS])
         next_pending = 1'b1;
   end

   // Registers only.
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pending <= 1'b0;
         ack_armed <= 1'b0;
      end
      else
      begin
         pending <= next_pending;
         ack_armed <= next_ack_armed;
      end
   end

   // Data bus drive: full status word on a read, only bit 4 low on a poll.
   always_comb
   begin
      next_data = 8'h00;
      next_data_oe = 8'h00;
      if (bus_rd_i && (bus_addr_i == ADDR_STATUS))
      begin
         next_data[STAT_ACTIVE_POS] = (state == SWP_SWEEP);
         next_data[STAT_HOLDOFF_POS] = hold_busy;
         next_data[STAT_PENDING_POS] = pending;
         next_data[STAT_SRQ_LINE_POS] = service_request_line_i;
         next_data_oe = 8'hff;
      end
      else if (poll_i && bus_addr_i[ADDR_MSB_POS] && pending)
      begin
         next_data[POLL_RESPONSE_BIT] = 1'b0;
         next_data_oe[POLL_RESPONSE_BIT] = 1'b1;
      end
   end

   // Sweep outputs; the gate is forced off and blanking on by control bit 2.
   assign next_active = (next_state == SWP_SWEEP);
   assign next_gate = next_active && !next_blank_cmd;
   assign next_blank = next_blank_cmd || !next_active;

   // Output flops.
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         bus_data_o <= 8'h00;
         bus_data_oe_o <= 8'h00;
         service_request_line_o <= 1'b0;
         service_request_line_oe_o <= 1'b0;
         sweep_active_o <= 1'b0;
         sweep_gate_o <= 1'b0;
         blank_o <= 1'b1;
         sweep_rate_o <= '0;
         manual_sweep_o <= 1'b0;
         external_sweep_o <= 1'b0;
         marker_dac_o <= '0;
      end
      else
      begin
         bus_data_o <= next_data;
         bus_data_oe_o <= next_data_oe;
         service_request_line_o <= 1'b0;
         service_request_line_oe_o <= next_pending;
         sweep_active_o <= next_active;
         sweep_gate_o <= next_gate;
         blank_o <= next_blank;
         sweep_rate_o <= next_sub[1][RATE_W-1:0];
         manual_sweep_o <= (next_sub[1][RATE_W-1:0] == RATE_MANUAL);
         external_sweep_o <= (next_sub[1][RATE_W-1:0] == RATE_EXTERNAL);
         marker_dac_o <= {next_sub[3][3:0], next_sub[2]};
      end
   end

endmodule

// ===== testbench/swp_sweep_ctrl_asserts.sv
`timescale 1ns/1ps
module swp_checker
   import swp_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Host side of the bus.
   input wire logic [7:0] bus_addr_i,
   input wire logic [7:0] bus_data_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic poll_i,
   // Board side of the bus.
   input wire logic [7:0] bus_data_o,
   input wire logic [7:0] bus_data_oe_o,
   input wire logic service_request_line_i,
   input wire logic service_request_line_o,
   input wire logic service_request_line_oe_o,
   // Sweep.
   input wire logic end_of_sweep_event_i,
   input wire logic sweep_active_o,
   input wire logic sweep_gate_o,
   input wire logic blank_o,
   input wire logic [RATE_W-1:0] sweep_rate_o,
   input wire logic manual_sweep_o,
   input wire logic external_sweep_o
);
   // One clock domain, so every check shares its clock and reset.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_srq_rise:
   assert property ($rose(service_request_line_oe_o) |->
      $past(end_of_sweep_event_i) && !$past(end_of_sweep_event_i, 2))
      else $error("request rose without end of sweep");
   a_srq_drain:
   assert property (service_request_line_o == 1'b0) else $error("request line driven high");
   a_poll_answer:
   assert property (poll_i && bus_addr_i[ADDR_MSB_POS] && service_request_line_oe_o |=>
      bus_data_oe_o[4] && !bus_data_o[4]) else $error("no poll answer");
   a_bus_quiet:
   assert property (!$past(poll_i) && !$past(bus_rd_i && bus_addr_i == ADDR_STATUS) |->
      bus_data_oe_o == 8'h00) else $error("bus driven unasked");
   a_status_read:
   assert property (bus_rd_i && !poll_i && bus_addr_i == ADDR_STATUS |=>
      bus_data_oe_o == 8'hff && bus_data_o[7:4] == 4'h0 &&
      bus_data_o[3] == $past(service_request_line_i)) else $error("bad status read");
   a_gate_blank:
   assert property (sweep_gate_o == !blank_o) else $error("gate and blank disagree");
   a_idle_blank:
   assert property (!sweep_active_o |-> blank_o && !sweep_gate_o) else $error("idle not blanked");
   a_rate_decode:
   assert property (manual_sweep_o == (sweep_rate_o == RATE_MANUAL) &&
      external_sweep_o == (sweep_rate_o == RATE_EXTERNAL)) else $error("bad rate decode");
   a_srq_release:
   assert property ($fell(service_request_line_oe_o) |-> !$past(poll_i) && $past(poll_i, 2))
      else $error("request dropped without poll fall");
   a_abort_stop:
   assert property (bus_wr_i && bus_addr_i == ADDR_CTRL && bus_data_i[0] && !bus_data_i[3] &&
      sweep_active_o |=> !sweep_active_o) else $error("abort ignored");
endmodule

bind swp_sweep_ctrl swp_checker u_chk (.clk_i, .arst_n_i, .bus_addr_i, .bus_data_i,
   .bus_wr_i, .bus_rd_i, .poll_i, .bus_data_o, .bus_data_oe_o, .service_request_line_i,
   .service_request_line_o, .service_request_line_oe_o, .end_of_sweep_event_i,
   .sweep_active_o, .sweep_gate_o, .blank_o, .sweep_rate_o, .manual_sweep_o,
   .external_sweep_o);

// ===== testbench/swp_host.sv
`timescale 1ns/1ps
module swp_host
(
   // Clock.
   input wire logic clk_i,
   // Board drive.
   input wire logic [7:0] dev_data_i,
   input wire logic [7:0] dev_oe_i,
   // Host drive and the resolved data bus.
   output logic [7:0] addr_o,
   output logic [7:0] data_o,
   output logic wr_o,
   output logic rd_o,
   output logic poll_o
);
   logic [7:0] drv = 8'h00;
   logic host_en = 1'b0;
   initial addr_o = 8'h00;
   initial wr_o = 1'b0;
   initial rd_o = 1'b0;
   initial poll_o = 1'b0;
   // Open-collector bus: any party pulls low, released lines float high.
   assign data_o = (~dev_oe_i | dev_data_i) & (host_en ? drv : 8'hff);

   task automatic write(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_i);
      addr_o = a;
      drv = v;
      host_en = 1'b1;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      host_en = 1'b0;
   endtask

   // Data is taken off the clock edge, a cycle and a half after the board answered.
   task automatic read(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      repeat (2) @(negedge clk_i);
      v = data_o;
      rd_o = 1'b0;
   endtask

   // Poll then acknowledge; gap slows the host down.
   task automatic poll_ack(output logic [7:0] seen, input int gap);
      @(negedge clk_i);
      addr_o = 8'hff;
      @(negedge clk_i);
      poll_o = 1'b1;
      repeat (3 + gap) @(negedge clk_i);
      seen = data_o;
      poll_o = 1'b0;
      addr_o = 8'h7f;
      drv = 8'hef;
      host_en = 1'b1;
      @(negedge clk_i);
      poll_o = 1'b1;
      repeat (gap) @(negedge clk_i);
      @(negedge clk_i);
      poll_o = 1'b0;
      @(negedge clk_i);
      host_en = 1'b0;
   endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import swp_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [7:0] addr, dbus, doo, doe, d;
   logic wr, rd, poll, so, soe, act, gate, blank, man, ext;
   logic [4:0] rate;
   logic [11:0] mark;
   int err_count = 0;
   int cmp_count = 0;
   // Clock at 200 MHz.
   always #2.5 clk_i = ~clk_i;
   // Only this board shares the request line here; it idles high.
   wire srq = soe ? so : 1'b1;

   swp_sweep_ctrl DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_addr_i(addr),
      .bus_data_i(dbus), .bus_wr_i(wr), .bus_rd_i(rd), .poll_i(poll), .bus_data_o(doo),
      .bus_data_oe_o(doe), .service_request_line_i(srq), .service_request_line_o(so),
      .service_request_line_oe_o(soe), .end_of_sweep_event_i(ev[0]), .trig_internal_i(ev[1]),
      .trig_external_i(ev[2]), .trig_line_i(ev[3]), .sweep_active_o(act),
      .sweep_gate_o(gate), .blank_o(blank), .sweep_rate_o(rate), .manual_sweep_o(man),
      .external_sweep_o(ext), .marker_dac_o(mark));
   swp_host u_host (.clk_i(clk_i), .dev_data_i(doo), .dev_oe_i(doe), .addr_o(addr),
      .data_o(dbus), .wr_o(wr), .rd_o(rd), .poll_o(poll));

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Index 0 is end of sweep, 1 to 3 the internal, external and line triggers.
   task automatic pulse(input int k);
      @(negedge clk_i);
      ev[k] = 1'b1;
      repeat (3) @(negedge clk_i);
      ev[k] = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask

   task automatic sub0(input logic [7:0] v);
      u_host.write(ADDR_CTRL, 8'h00);
      u_host.write(ADDR_SUB, v);
   endtask

   task automatic wchk(input logic [7:0] a, input logic [7:0] v, input logic [11:0] e);
      u_host.write(a, v);
      @(negedge clk_i);
      chk(12'({man, ext, rate}), e);
   endtask

   task automatic t_regs();
      wchk(ADDR_CTRL, 8'h40, 12'h000);
      wchk(ADDR_SUB, 8'h1f, 12'h05f);
      wchk(ADDR_SUB, 8'h0f, 12'h02f);
      wchk(ADDR_SUB, 8'h0b, 12'h00b);
      wchk(8'h2f, 8'h1f, 12'h00b);
      u_host.write(ADDR_CTRL, 8'h80);
      u_host.write(ADDR_SUB, 8'h5a);
      u_host.write(ADDR_CTRL, 8'hc0);
      u_host.write(ADDR_SUB, 8'h03);
      @(negedge clk_i);
      chk(mark, 12'h35a);
      $display("register test done");
   endtask

   // Abort, then time the rearm for each holdoff code; code 3 must act as long.
   task automatic t_holdoff();
      int n;
      int exp [4] = '{400, 2000, 4000, 4000};
      for (int c = 0; c < 4; c++)
      begin
         sub0(8'(c << 5));
         u_host.write(ADDR_CTRL, 8'h01);
         @(negedge clk_i);
         chk(12'(act), 12'h0);
         n = 0;
         while (act !== 1'b1 && n < 5000)
         begin
            @(negedge clk_i);
            n++;
         end
         chk(12'(n >= exp[c] - 2 && n <= exp[c] + 4), 12'h1);
      end
      $display("holdoff test done");
   endtask

   task automatic t_trig();
      for (int s = 1; s < 4; s++)
      begin
         sub0(8'(s << 3));
         u_host.write(ADDR_CTRL, 8'h01);
         repeat (410) @(negedge clk_i);
         pulse(s % 3 + 1);
         chk(12'(act), 12'h0);
         pulse(s);
         chk(12'(act), 12'h1);
      end
      u_host.write(ADDR_CTRL, 8'h03);
      repeat (410) @(negedge clk_i);
      pulse(3);
      chk(12'(act), 12'h0);
      u_host.write(ADDR_CTRL, 8'h00);
      pulse(3);
      chk(12'(act), 12'h1);
      $display("trigger test done");
   endtask

   task automatic t_single();
      sub0(8'h01);
      u_host.write(ADDR_CTRL, 8'h01);
      repeat (410) @(negedge clk_i);
      chk(12'(act), 12'h0);
      u_host.write(ADDR_CTRL, 8'h08);
      @(negedge clk_i);
      chk(12'(act), 12'h1);
      u_host.write(ADDR_CTRL, 8'h04);
      @(negedge clk_i);
      chk(12'({gate, blank}), 12'h1);
      u_host.write(ADDR_CTRL, 8'h00);
      @(negedge clk_i);
      chk(12'({gate, blank}), 12'h2);
      // A manual rate code starts a sweep at once, even in single mode.
      u_host.write(ADDR_CTRL, 8'h41);
      repeat (410) @(negedge clk_i);
      chk(12'(act), 12'h0);
      wchk(ADDR_SUB, 8'h1f, 12'h05f);
      chk(12'(act), 12'h1);
      u_host.write(ADDR_SUB, 8'h0b);
      $display("single sweep test done");
   endtask

   task automatic t_poll();
      sub0(8'h02);
      pulse(0);
      chk(12'({act, soe}), 12'h1);
      u_host.read(ADDR_STATUS, d);
      chk(12'(d[3:2]), 12'h1);
      u_host.poll_ack(d, 3);
      chk(12'(d[4]), 12'h0);
      @(negedge clk_i);
      chk(12'(soe), 12'h0);
      repeat (410) @(negedge clk_i);
      pulse(0);
      chk(12'(soe), 12'h1);
      u_host.poll_ack(d, 0);
      @(negedge clk_i);
      chk(12'(soe), 12'h0);
      u_host.poll_ack(d, 0);
      chk(12'(d[4]), 12'h1);
      sub0(8'h00);
      repeat (410) @(negedge clk_i);
      pulse(0);
      chk(12'(soe), 12'h0);
      $display("poll test done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // The tests need about 14000 cycles; a hang is cut off well beyond that.
   initial
   begin
      repeat (60000) @(posedge clk_i);
      err_count++;
      end_of_test();
   end

   initial
   begin
      repeat (16) @(negedge clk_i);
      chk(12'({act, blank, soe}), 12'h2);
      arst_n_i = 1'b1;
      t_regs();
      t_holdoff();
      t_trig();
      t_single();
      t_poll();
      end_of_test();
   end
endmodule
